// ### design/mcx_exec.v
/*
  Execution unit of the 8-bit core for everything but load and store:
  arithmetic and logic, relative branches, bit test and branch, bit set
  and clear, long jump and call, and control instructions.
  Assumes program memory and data space answer combinationally to the
  registered addresses, and that wake and watchdog select come from logic
  on the same clock.
*/
// How it works
// RQ1: add/and/compare/subtract use accumulator plus memory/immediate
// RQ2: clear/inc/dec reach all 256 data addresses
// RQ3: complement, rotate, shift work on accumulator only
// RQ4: short branch displacement 5-bit, -15 to +16
// RQ5: branch only when carry/zero condition holds
// RQ6: bit branch on clear/set, 8-bit displacement
// RQ7: three opcode bits select the bit
// RQ8: bit set/clear changes one bit only
// RQ9: jump/call carry 12-bit target, call pushes return
// RQ10: stop becomes wait when watchdog selected
// RQ11: immediate byte comes from program memory
// RQ12: two pointer and two short registers
// RQ13: tested bit copied into carry always
// RQ14: pointers and short registers at 80h-83h
// RQ15: opcode bit 4 picks the pointer
// RQ16: 4, 2 or 5 cycles per instruction
// RQ17: flags changed only where the tables say
`timescale 1ns/100ps
`include "mcx_exec_map.vh"

module mcx_exec (
  input wire core_clk_i,
  input wire reset_i,
  input wire [7:0] pm_data_i,
  input wire [7:0] ds_rdata_i,
  input wire wdg_sel_i,
  input wire wake_i,
  output wire [11:0] pm_addr_o,
  output wire [7:0] ds_addr_o,
  output wire [7:0] ds_wdata_o,
  output wire ds_we_o,
  output wire [7:0] acc_o,
  output wire flag_c_o,
  output wire flag_z_o,
  output wire wait_o,
  output wire stop_o
);

  // ==========================================================
  // states
  localparam [2:0] ST_FETCH = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_HALT = 3'b100;

  // ==========================================================
  // decode helpers
  // class of an opcode; used at fetch and for the length
  function [3:0] mcx_class;
    input [7:0] op;
    begin
      if (op[0] == 1'b0) begin
        mcx_class = `MCX_CLS_BR;
      end else begin
        case (op[3:0])
          `MCX_LO_CALL: mcx_class = `MCX_CLS_CALL;
          `MCX_LO_JUMP: mcx_class = `MCX_CLS_JUMP;
          `MCX_LO_BTST: mcx_class = `MCX_CLS_BTST;
          `MCX_LO_BSET: mcx_class = `MCX_CLS_BSET;
          `MCX_LO_IND: mcx_class = (op[7:5] == 3'h7) ? `MCX_CLS_NOP : `MCX_CLS_IND;
          // immediate only exists for the accumulator pair ops
          `MCX_LO_DIR: mcx_class = op[4] ? ((op[7] == 1'b0) ? `MCX_CLS_IMM : `MCX_CLS_NOP) :
            ((op[7:5] == 3'h7) ? `MCX_CLS_NOP : `MCX_CLS_DIR);
          `MCX_LO_SHORT: mcx_class = op[4] ? `MCX_CLS_SHORT : `MCX_CLS_NOP;
          `MCX_LO_INH: mcx_class = `MCX_CLS_INH;
          default: mcx_class = `MCX_CLS_NOP;
        endcase
      end
    end
  endfunction

  // total cycles of an opcode, fetch included
  function [2:0] mcx_len;
    input [7:0] op;
    reg [3:0] cls;
    begin
      cls = mcx_class(op);
      case (cls)
        `MCX_CLS_BTST: mcx_len = `MCX_LEN_BTST; // [RQ16]
        `MCX_CLS_CALL, `MCX_CLS_JUMP: mcx_len = `MCX_LEN_JUMP; // [RQ16]
        `MCX_CLS_BSET, `MCX_CLS_IND, `MCX_CLS_DIR, `MCX_CLS_IMM, `MCX_CLS_SHORT: mcx_len = `MCX_LEN_ALU;
        `MCX_CLS_INH: mcx_len = (op[7:6] == 2'h0) ? `MCX_LEN_ALU : `MCX_LEN_SHORT; // [RQ16]
        default: mcx_len = `MCX_LEN_SHORT; // [RQ16]
      endcase
    end
  endfunction

  // ==========================================================
  // state
  reg [2:0] state_q;
  reg [11:0] pc_q;
  reg [11:0] pm_addr_q;
  reg [7:0] op_q;
  reg [3:0] cls_q;
  reg [2:0] len_q;
  reg [2:0] cnt_q;
  reg [7:0] b2_q;
  reg [7:0] b3_q;
  reg [7:0] ds_addr_q;
  reg [7:0] ds_wdata_q;
  reg ds_we_q;
  reg [7:0] acc_q;
  reg c_q;
  reg z_q;
  reg wait_q;
  reg stop_q;
  reg [2:0] sp_q;
  reg [13:0] stk_q [0:5];

  // next values from the execute step
  reg [11:0] npc_d;
  reg [7:0] acc_d;
  reg c_d;
  reg z_d;
  reg we_d;
  reg [7:0] wdata_d;
  reg push_d;
  reg pop_d;
  reg halt_d;
  reg stop_d;

  wire last_w = (state_q == ST_RUN) && (cnt_q == len_q - 3'h1);
  wire [7:0] opnd_w = (cls_q == `MCX_CLS_IMM) ? b2_q : ds_rdata_i; // [RQ1] [RQ11]
  wire [8:0] sum_w = {1'b0, acc_q} + {1'b0, opnd_w};
  wire [8:0] dif_w = {1'b0, acc_q} - {1'b0, opnd_w};
  wire [7:0] mask_w = 8'h01 << op_q[7:5]; // [RQ7]
  wire [2:0] pop_idx_w = (sp_q == 3'h0) ? 3'h0 : sp_q - 3'h1;
  wire [13:0] pop_w = stk_q[pop_idx_w];
  wire [7:0] inc_w = ds_rdata_i + 8'h01;
  wire [7:0] dec_w = ds_rdata_i - 8'h01;

  // ==========================================================
  // execute: results of the instruction in its last cycle
  always @* begin
    npc_d = pc_q + 12'h001;
    acc_d = acc_q;
    c_d = c_q;
    z_d = z_q;
    we_d = 1'b0;
    wdata_d = ds_rdata_i;
    push_d = 1'b0;
    pop_d = 1'b0;
    halt_d = 1'b0;
    stop_d = 1'b0;
    case (cls_q)
      `MCX_CLS_BR: begin
        // selected condition; displacement is relative to the next byte
        if ((op_q[2:1] == 2'h0 && !z_q) || (op_q[2:1] == 2'h1 && !c_q) ||
            (op_q[2:1] == 2'h2 && z_q) || (op_q[2:1] == 2'h3 && c_q)) begin // [RQ5]
          npc_d = pc_q + 12'h001 + {{7{op_q[7]}}, op_q[7:3]}; // [RQ4]
        end
      end
      `MCX_CLS_CALL: begin
        npc_d = {op_q[7:4], b2_q}; // [RQ9]
        push_d = 1'b1; // [RQ9]
      end
      `MCX_CLS_JUMP: begin
        npc_d = {op_q[7:4], b2_q}; // [RQ9]
      end
      `MCX_CLS_BTST: begin
        c_d = ds_rdata_i[op_q[7:5]]; // [RQ13]
        npc_d = pc_q + 12'h003;
        if (ds_rdata_i[op_q[7:5]] == op_q[4]) begin // [RQ6]
          npc_d = pc_q + 12'h002 + {{4{b3_q[7]}}, b3_q}; // [RQ6]
        end
      end
      `MCX_CLS_BSET: begin
        npc_d = pc_q + 12'h002;
        we_d = 1'b1;
        wdata_d = op_q[4] ? (ds_rdata_i | mask_w) : (ds_rdata_i & ~mask_w); // [RQ8]
      end
      `MCX_CLS_IND, `MCX_CLS_DIR, `MCX_CLS_IMM: begin
        if (cls_q != `MCX_CLS_IND) begin
          npc_d = pc_q + 12'h002;
        end
        case (op_q[7:5])
          `MCX_K_ADD: begin
            acc_d = sum_w[7:0]; // [RQ1]
            c_d = sum_w[8];
            z_d = (sum_w[7:0] == 8'h00);
          end
          `MCX_K_AND: begin
            acc_d = acc_q & opnd_w; // [RQ1]
            c_d = 1'b0;
            z_d = ((acc_q & opnd_w) == 8'h00);
          end
          `MCX_K_CP, `MCX_K_SUB: begin
            // compare keeps the accumulator, only flags move
            if (op_q[7:5] == `MCX_K_SUB) begin
              acc_d = dif_w[7:0]; // [RQ1]
            end
            c_d = dif_w[8];
            z_d = (dif_w[7:0] == 8'h00);
          end
          `MCX_K_INC: begin
            we_d = 1'b1;
            wdata_d = inc_w; // [RQ2]
            z_d = (inc_w == 8'h00); // [RQ17]
          end
          `MCX_K_DEC: begin
            we_d = 1'b1;
            wdata_d = dec_w; // [RQ2]
            z_d = (dec_w == 8'h00); // [RQ17]
          end
          `MCX_K_CLR: begin
            we_d = 1'b1;
            wdata_d = 8'h00; // [RQ2]
          end
          default: begin
            we_d = 1'b0;
          end
        endcase
      end
      `MCX_CLS_SHORT: begin
        we_d = 1'b1;
        wdata_d = op_q[5] ? dec_w : inc_w;
        z_d = op_q[5] ? (dec_w == 8'h00) : (inc_w == 8'h00); // [RQ17]
      end
      `MCX_CLS_INH: begin
        case (op_q[7:4])
          `MCX_I_COM: begin
            acc_d = ~acc_q; // [RQ3]
            c_d = acc_q[7];
            z_d = (acc_q == 8'hff);
          end
          `MCX_I_RLC: begin
            acc_d = {acc_q[6:0], c_q}; // [RQ3]
            c_d = acc_q[7];
            z_d = ({acc_q[6:0], c_q} == 8'h00);
          end
          `MCX_I_SLA: begin
            acc_d = {acc_q[6:0], 1'b0}; // [RQ3]
            c_d = acc_q[7];
            z_d = (acc_q[6:0] == 7'h00);
          end
          `MCX_I_CLRA: begin
            acc_d = 8'h00;
            c_d = 1'b0;
            z_d = 1'b1;
          end
          `MCX_I_RET, `MCX_I_RETURN_FROM_INTERRUPT: begin
            pop_d = 1'b1;
            npc_d = pop_w[11:0];
            // only the interrupt return restores the saved flags
            if (op_q[7:4] == `MCX_I_RETURN_FROM_INTERRUPT) begin // [RQ17]
              c_d = pop_w[12];
              z_d = pop_w[13];
            end
          end
          `MCX_I_STOP: begin
            halt_d = 1'b1;
            stop_d = ~wdg_sel_i; // [RQ10]
          end
          `MCX_I_WAIT: begin
            halt_d = 1'b1;
          end
          default: begin
            halt_d = 1'b0;
          end
        endcase
      end
      default: begin
        npc_d = pc_q + 12'h001;
      end
    endcase
  end

  // ==========================================================
  // sequencer: fetch, operand bytes, data reads, completion
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      state_q <= ST_FETCH;
      pc_q <= `MCX_RESET_PC;
      pm_addr_q <= `MCX_RESET_PC;
      op_q <= 8'h00;
      cls_q <= `MCX_CLS_NOP;
      len_q <= `MCX_LEN_SHORT;
      cnt_q <= 3'h0;
      b2_q <= 8'h00;
      b3_q <= 8'h00;
      ds_addr_q <= 8'h00;
      ds_wdata_q <= 8'h00;
      ds_we_q <= 1'b0;
      acc_q <= 8'h00;
      c_q <= 1'b0;
      z_q <= 1'b0;
      wait_q <= 1'b0;
      stop_q <= 1'b0;
      sp_q <= 3'h0;
    end else begin
      // a write lasts exactly the cycle after the last one
      ds_we_q <= 1'b0;
      case (state_q)
        ST_FETCH: begin
          op_q <= pm_data_i;
          cls_q <= mcx_class(pm_data_i);
          len_q <= mcx_len(pm_data_i);
          cnt_q <= 3'h1;
          pm_addr_q <= pc_q + 12'h001;
          state_q <= ST_RUN;
        end
        ST_RUN: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == 3'h1) begin
            b2_q <= pm_data_i; // [RQ11]
            pm_addr_q <= pc_q + 12'h002;
            if (cls_q == `MCX_CLS_IND) begin
              ds_addr_q <= op_q[4] ? `MCX_ADDR_PTR_Y : `MCX_ADDR_PTR_X; // [RQ15] [RQ12] [RQ14]
            end else if (cls_q == `MCX_CLS_SHORT) begin
              ds_addr_q <= `MCX_ADDR_PTR_X + {6'h00, op_q[7:6]}; // [RQ12] [RQ14]
            end else begin
              ds_addr_q <= pm_data_i; // [RQ2]
            end
          end
          if (cnt_q == 3'h2) begin
            b3_q <= pm_data_i;
            // pointer contents become the operand address
            if (cls_q == `MCX_CLS_IND) begin
              ds_addr_q <= ds_rdata_i; // [RQ12]
            end
          end
          if (last_w) begin
            pc_q <= npc_d;
            pm_addr_q <= npc_d;
            acc_q <= acc_d;
            c_q <= c_d; // [RQ17]
            z_q <= z_d; // [RQ17]
            ds_we_q <= we_d;
            ds_wdata_q <= wdata_d;
            if (push_d && sp_q != `MCX_STACK_DEPTH) begin
              sp_q <= sp_q + 3'h1;
            end
            if (pop_d && sp_q != 3'h0) begin
              sp_q <= sp_q - 3'h1;
            end
            wait_q <= halt_d & ~stop_d; // [RQ10]
            stop_q <= stop_d;
            state_q <= halt_d ? ST_HALT : ST_FETCH;
          end
        end
        ST_HALT: begin
          if (wake_i) begin
            wait_q <= 1'b0;
            stop_q <= 1'b0;
            state_q <= ST_FETCH;
          end
        end
        default: begin
          state_q <= ST_FETCH;
        end
      endcase
    end
  end

  // ==========================================================
  // return stack; a full stack overwrites its top entry
  always @(posedge core_clk_i) begin
    if (!reset_i && last_w && push_d) begin
      stk_q[(sp_q == `MCX_STACK_DEPTH) ? `MCX_STACK_TOP : sp_q] <= {z_q, c_q, pc_q + 12'h002}; // [RQ9]
    end
  end

  // outputs straight from flops
  assign pm_addr_o = pm_addr_q;
  assign ds_addr_o = ds_addr_q;
  assign ds_wdata_o = ds_wdata_q;
  assign ds_we_o = ds_we_q;
  assign acc_o = acc_q;
  assign flag_c_o = c_q;
  assign flag_z_o = z_q;
  assign wait_o = wait_q;
  assign stop_o = stop_q;

endmodule // mcx_exec

// ### design/mcx_exec_map.vh
/*
  Constants for the core execution unit: data space locations of the
  pointer and short registers, opcode field codes, instruction classes,
  cycle counts and reset values.
  Assumes it is included by bare name from the design file.
*/
`ifndef MCX_EXEC_MAP_VH
`define MCX_EXEC_MAP_VH

// ==========================================================
// data space locations
`define MCX_ADDR_PTR_X 8'h80
`define MCX_ADDR_PTR_Y 8'h81
`define MCX_ADDR_SHORT_V 8'h82
`define MCX_ADDR_SHORT_W 8'h83

// ==========================================================
// opcode low nibble codes
`define MCX_LO_CALL 4'h1
`define MCX_LO_JUMP 4'h9
`define MCX_LO_BTST 4'h3
`define MCX_LO_BSET 4'hb
`define MCX_LO_IND 4'h7
`define MCX_LO_DIR 4'hf
`define MCX_LO_SHORT 4'h5
`define MCX_LO_INH 4'hd

// ==========================================================
// instruction classes
`define MCX_CLS_NOP 4'h0
`define MCX_CLS_BR 4'h1
`define MCX_CLS_CALL 4'h2
`define MCX_CLS_JUMP 4'h3
`define MCX_CLS_BTST 4'h4
`define MCX_CLS_BSET 4'h5
`define MCX_CLS_IND 4'h6
`define MCX_CLS_DIR 4'h7
`define MCX_CLS_IMM 4'h8
`define MCX_CLS_SHORT 4'h9
`define MCX_CLS_INH 4'ha

// ==========================================================
// arithmetic kinds in opcode bits 7..5
`define MCX_K_ADD 3'h0
`define MCX_K_AND 3'h1
`define MCX_K_CP 3'h2
`define MCX_K_SUB 3'h3
`define MCX_K_INC 3'h4
`define MCX_K_DEC 3'h5
`define MCX_K_CLR 3'h6

// inherent codes in opcode bits 7..4
`define MCX_I_COM 4'h0
`define MCX_I_RLC 4'h1
`define MCX_I_SLA 4'h2
`define MCX_I_CLRA 4'h3
`define MCX_I_RET 4'h5
`define MCX_I_RETURN_FROM_INTERRUPT 4'h6
`define MCX_I_STOP 4'h7
`define MCX_I_WAIT 4'h8

// ==========================================================
// cycle counts per instruction
`define MCX_LEN_ALU 3'h4
`define MCX_LEN_SHORT 3'h2
`define MCX_LEN_BTST 3'h5
`define MCX_LEN_JUMP 3'h4

// ==========================================================
// stack and reset values
`define MCX_STACK_DEPTH 3'h6
`define MCX_STACK_TOP 3'h5
`define MCX_RESET_PC 12'h000

`endif

// ### sim/mcx_exec_asserts.sv
/*
  Port checker for the execution unit: memory writes, halt states and reset.
  Assumes one core clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
// ====================================================
// checker
module mcx_exec_chk (
  input wire core_clk_i,
  input wire reset_i,
  input wire wdg_sel_i,
  input wire wake_i,
  input wire [11:0] pm_addr_o,
  input wire [7:0] ds_addr_o,
  input wire ds_we_o,
  input wire [7:0] acc_o,
  input wire flag_c_o,
  input wire flag_z_o,
  input wire wait_o,
  input wire stop_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);
  // either halt state counts as halted
  wire halted = wait_o | stop_o;
  AST_RESET_STATE: assert property ($fell(reset_i) |->
    pm_addr_o == 12'h000 && acc_o == 8'h00 && !flag_c_o && !flag_z_o) else $error("state after reset not clear");
  AST_WE_PULSE: assert property (ds_we_o |=> !ds_we_o)
    else $error("write strobe longer than one cycle");
  AST_WE_KEEPS_CARRY: assert property (ds_we_o |-> $stable(flag_c_o))
    else $error("memory write changed carry");
  AST_WE_KEEPS_ACC: assert property (ds_we_o |-> $stable(acc_o))
    else $error("memory write changed accumulator");
  AST_WE_ADDR_HOLD: assert property (ds_we_o |=> $stable(ds_addr_o))
    else $error("write address moved under the strobe");
  AST_NO_STOP_WDG: assert property ($rose(stop_o) |-> !wdg_sel_i)
    else $error("stop taken with watchdog selected");
  AST_HALT_EXCL: assert property (!(wait_o && stop_o))
    else $error("wait and stop both high");
  AST_HALT_HOLD: assert property (halted && $past(halted) && !wake_i |=> $stable(pm_addr_o) && !ds_we_o)
    else $error("halted core moved");
  AST_HALT_FLAGS: assert property (halted && $past(halted) |-> $stable(acc_o) && $stable({flag_c_o, flag_z_o}))
    else $error("halted core changed state");
  AST_WAKE: assert property (halted && wake_i |-> ##[1:2] !halted)
    else $error("wake did not end halt");
endmodule // mcx_exec_chk

bind mcx_exec mcx_exec_chk u_chk (.core_clk_i(core_clk_i), .reset_i(reset_i), .wdg_sel_i(wdg_sel_i),
  .wake_i(wake_i), .pm_addr_o(pm_addr_o), .ds_addr_o(ds_addr_o), .ds_we_o(ds_we_o), .acc_o(acc_o),
  .flag_c_o(flag_c_o), .flag_z_o(flag_z_o), .wait_o(wait_o), .stop_o(stop_o));

// ### sim/mcx_mem_model.sv
/*
  Program memory and 256-byte data space facing the execution unit.
  Assumes the bench loads contents by hierarchical write before each boot applies reset.
*/
`timescale 1ns/100ps
// ====================================================
// memories
module mcx_mem_model (
  input wire core_clk_i,
  input wire [11:0] pm_addr_i,
  input wire [7:0] ds_addr_i,
  input wire [7:0] ds_wdata_i,
  input wire ds_we_i,
  output wire [7:0] pm_data_o,
  output wire [7:0] ds_rdata_o
);
  reg [7:0] pm [0:4095];
  reg [7:0] ds [0:255];
  integer k;
  // empty program is no-operation opcodes, so stray fetches stay harmless
  initial begin
    for (k = 0; k < 4096; k = k + 1) pm[k] = 8'h4d;
    for (k = 0; k < 256; k = k + 1) ds[k] = 8'h00;
  end
  // both answer in the cycle the address stands
  assign pm_data_o = pm[pm_addr_i];
  assign ds_rdata_o = ds[ds_addr_i];
  // write lands at the edge closing the strobe cycle
  always @(posedge core_clk_i) begin
    if (ds_we_i) begin
      ds[ds_addr_i] <= ds_wdata_i;
    end
  end
endmodule // mcx_mem_model

// ### sim/tb_top.sv
/*
  Self-checking bench for the execution unit: arithmetic, memory and bit
  operations, branches and calls, halt entry and wake.
  Assumes the memory model answers combinationally.
*/
`timescale 1ns/100ps
// ====================================================
// bench
module tb_top;
  reg core_clk_i = 1'b0;
  reg reset_i = 1'b1;
  reg wdg_sel_i = 1'b0;
  reg wake_i = 1'b0;
  wire [11:0] pm_addr_o;
  wire [7:0] pm_data_i, ds_rdata_i, ds_addr_o, ds_wdata_o, acc_o;
  wire ds_we_o, flag_c_o, flag_z_o, wait_o, stop_o;
  integer fails = 0;
  integer compares = 0;
  // next pc after each branch-program step, and its cycle count
  localparam [119:0] NXT = {12'h001, 12'h005, 12'h017, 12'h008, 12'h00b, 12'h3a5, 12'h123, 12'h3a7, 12'h3a8, 12'h3ab};
  localparam [39:0] CYC = {4'd2, 4'd2, 4'd5, 4'd2, 4'd5, 4'd4, 4'd4, 4'd2, 4'd2, 4'd2};
  // 10 MHz core clock
  initial begin
    forever #50 core_clk_i = ~core_clk_i;
  end
  mcx_exec u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .pm_data_i(pm_data_i), .ds_rdata_i(ds_rdata_i),
    .wdg_sel_i(wdg_sel_i), .wake_i(wake_i), .pm_addr_o(pm_addr_o), .ds_addr_o(ds_addr_o), .ds_wdata_o(ds_wdata_o),
    .ds_we_o(ds_we_o), .acc_o(acc_o), .flag_c_o(flag_c_o), .flag_z_o(flag_z_o), .wait_o(wait_o), .stop_o(stop_o));
  mcx_mem_model u_mem (.core_clk_i(core_clk_i), .pm_addr_i(pm_addr_o), .ds_addr_i(ds_addr_o),
    .ds_wdata_i(ds_wdata_o), .ds_we_i(ds_we_o), .pm_data_o(pm_data_i), .ds_rdata_o(ds_rdata_i));
  // ====================================================
  // shared tasks
  task chk(input [11:0] seen, input [11:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      if (fails == 0 && compares > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask
  // inputs move 1 ns after the edge, outputs are read there too
  task step(input integer n);
    begin
      repeat (n) @(posedge core_clk_i);
      #1;
    end
  endtask
  task acf(input [9:0] e);
    chk({2'b00, acc_o, flag_c_o, flag_z_o}, {2'b00, e});
  endtask
  // bytes packed first byte leftmost; a plain vector keeps older simulators happy
  task put(input [11:0] a, input integer n, input [103:0] v);
    integer j;
    begin
      for (j = 0; j < n; j = j + 1) u_mem.pm[a + j] = v[(n - 1 - j) * 8 +: 8];
    end
  endtask
  task boot;
    begin
      reset_i = 1'b1;
      step(10);
      reset_i = 1'b0;
    end
  endtask
  task halt_wait;
    integer n;
    begin
      n = 0;
      while ((wait_o | stop_o) !== 1'b1 && n < 20) begin
        step(1);
        n = n + 1;
      end
      if ((wait_o | stop_o) !== 1'b1) begin
        fails = fails + 1;
        give_verdict;
      end
    end
  endtask
  // ====================================================
  // scenarios
  task s_alu;
    begin
      put(12'h000, 9, {8'h1f, 8'h7f, 8'h0f, 8'h40, 8'h7f, 8'h01, 8'h3f, 8'h0f, 8'h57});
      u_mem.ds[8'h7f] = 8'h01;
      u_mem.ds[8'h40] = 8'h81;
      u_mem.ds[8'h81] = 8'h50;
      u_mem.ds[8'h50] = 8'h0f;
      boot;
      step(4);
      acf({8'h7f, 2'b00});
      step(4);
      acf({8'h00, 2'b11});
      step(4);
      acf({8'hff, 2'b10});
      step(4);
      acf({8'h0f, 2'b00});
      step(4);
      acf({8'h0f, 2'b01});
      chk({4'h0, ds_addr_o}, 12'h050);
      chk(pm_addr_o, 12'h009);
    end
  endtask
  task s_mem;
    begin
      put(12'h000, 13, {8'h8f, 8'h90, 8'hb5, 8'hcf, 8'ha0, 8'hbb, 8'h91, 8'h0b, 8'h92, 8'h3d, 8'h0d, 8'h1d, 8'h2d});
      u_mem.ds[8'h90] = 8'hff;
      u_mem.ds[8'h82] = 8'h01;
      u_mem.ds[8'ha0] = 8'h5a;
      u_mem.ds[8'h91] = 8'h00;
      u_mem.ds[8'h92] = 8'hff;
      boot;
      step(4);
      acf({8'h00, 2'b01});
      chk({3'h0, ds_we_o, ds_wdata_o}, 12'h100);
      chk({4'h0, ds_addr_o}, 12'h090);
      step(50);
      chk({4'h0, u_mem.ds[8'h90]}, 12'h000);
      chk({4'h0, u_mem.ds[8'h82]}, 12'h000);
      chk({4'h0, u_mem.ds[8'ha0]}, 12'h000);
      chk({4'h0, u_mem.ds[8'h91]}, 12'h020);
      chk({4'h0, u_mem.ds[8'h92]}, 12'h0fe);
      acf({8'hfc, 2'b10});
    end
  endtask
  task s_branch;
    integer j;
    begin
      put(12'h000, 2, {8'h2e, 8'h18});
      put(12'h005, 3, {8'h53, 8'h60, 8'h10});
      put(12'h008, 3, {8'h73, 8'h60, 8'h05});
      put(12'h00b, 2, {8'h39, 8'ha5});
      put(12'h017, 1, {8'h86});
      put(12'h3a5, 2, {8'h11, 8'h23});
      put(12'h123, 1, {8'h5d});
      put(12'h3a7, 2, {8'h0c, 8'h12});
      u_mem.ds[8'h60] = 8'h04;
      boot;
      for (j = 0; j < 10; j = j + 1) begin
        step(CYC[(9 - j) * 4 +: 4]);
        chk(pm_addr_o, NXT[(9 - j) * 12 +: 12]);
        if (j == 2 || j == 4) chk({11'h000, flag_c_o}, {11'h000, j == 2});
      end
      chk({11'h000, flag_z_o}, 12'h000);
    end
  endtask
  // clear acc, call, complement, then interrupt return restores call-time flags
  task s_return_from_interrupt;
    begin
      put(12'h000, 3, {8'h3d, 8'h21, 8'h50});
      put(12'h250, 2, {8'h0d, 8'h6d});
      boot;
      step(12);
      acf({8'hff, 2'b00});
      chk(pm_addr_o, 12'h251);
      step(2);
      acf({8'hff, 2'b01});
      chk(pm_addr_o, 12'h003);
    end
  endtask
  task s_halt;
    integer j;
    begin
      for (j = 0; j < 3; j = j + 1) begin
        u_mem.pm[0] = (j < 2) ? 8'h7d : 8'h8d;
        wdg_sel_i = (j == 1);
        boot;
        halt_wait;
        chk({10'h000, wait_o, stop_o}, (j == 0) ? 12'h001 : 12'h002);
        step(3);
        wake_i = 1'b1;
        step(3);
        chk({10'h000, wait_o, stop_o}, 12'h000);
        wake_i = 1'b0;
      end
    end
  endtask
  // main sequence, one place to end
  initial begin
    step(10);
    s_alu;
    s_mem;
    s_branch;
    s_return_from_interrupt;
    s_halt;
    give_verdict;
  end
endmodule // tb_top
